// *** tbrpc_trace_readout.v ***
// Trace buffer readout, fill counter and comparator C page extension
`include "tbrpc_defines.vh"

module tbrpc_trace_readout
(
  // Clock and reset
  input wire         clk,
  input wire         nrst,
  // Register port
  input wire [7:0]   regAddr,
  input wire [15:0]  regWrData,
  input wire         regWr,
  input wire         regRd,
  input wire         regByte,
  output reg [15:0]  regRdData_q,
  // Capture side from the trigger logic
  input wire         storeValid,
  input wire [15:0]  storeWord,
  input wire         sessionEnd,
  // Core page and low comparator C match
  input wire [5:0]   programPageIndex,
  input wire         lowAddrMatch,
  // Control towards the rest of the debug unit
  output reg         armed_q,
  output reg         beginTrigger_q,
  output reg [1:0]   captureMode_q,
  output reg         breakRequest_q,
  output reg         bufferFull_q,
  output wire        compCMatch_q
);

  // Control and status state
  reg        breakEnable_q;
  reg [5:0]  validWordCount_q;
  reg [5:0]  readPtr_q;
  reg [7:0]  pageExt_q;

  reg        armed_d;
  reg        beginTrigger_d;
  reg [1:0]  captureMode_d;
  reg        breakEnable_d;
  reg        breakRequest_d;
  reg        bufferFull_d;
  reg [5:0]  validWordCount_d;
  reg [5:0]  readPtr_d;
  reg [7:0]  pageExt_d;
  reg [15:0] regRdData_d;

  // Decoded accesses
  wire       wrControl;
  wire       wrPageExt;
  wire       rdTrace;
  wire       rdTraceWord;
  wire       armSet;
  wire       storeNow;
  wire       wrapNow;
  wire [15:0] ramWord;
  wire [7:0] fillCountReg;
  wire [7:0] controlReg;

  assign wrControl = regWr && (regAddr == `TBRPC_OFS_CONTROL_ONE);
  assign wrPageExt = regWr && (regAddr == `TBRPC_OFS_PAGE_EXT);

  // Byte address 1 of the trace word is a misaligned access
  assign rdTrace = regRd &&
                   ((regAddr | 8'h01) == (`TBRPC_OFS_TRACE_WORD | 8'h01));
  assign rdTraceWord = rdTrace && !regByte &&
                       (regAddr == `TBRPC_OFS_TRACE_WORD) && !armed_q;

  assign armSet = wrControl && regWrData[`TBRPC_CTL_ARM];

  // Storage runs only while armed
  assign storeNow = armed_q && storeValid && !armSet;
  assign wrapNow = storeNow && (validWordCount_q == `TBRPC_CNT_LAST);

  assign fillCountReg = {bufferFull_q, 1'b0, validWordCount_q};
  assign controlReg = {1'b0, armed_q, 1'b0, beginTrigger_q,
                       breakEnable_q, 1'b0, captureMode_q};

  // Control register, arm handling and automatic disarm
  always @*
  begin
    armed_d = armed_q;
    beginTrigger_d = beginTrigger_q;
    captureMode_d = captureMode_q;
    breakEnable_d = breakEnable_q;
    breakRequest_d = 1'b0;
    if (wrControl)
    begin
      armed_d = regWrData[`TBRPC_CTL_ARM];
      beginTrigger_d = regWrData[`TBRPC_CTL_BEGIN];
      breakEnable_d = regWrData[`TBRPC_CTL_BRK];
      captureMode_d = regWrData[`TBRPC_CTL_CAP_HI:`TBRPC_CTL_CAP_LO];
    end
    else if (armed_q)
    begin
      // Begin-trigger session completes on the first fill
      if (wrapNow && !bufferFull_q && beginTrigger_q)
      begin
        armed_d = 1'b0;
        breakRequest_d = breakEnable_q;
      end
      // End-trigger session completes on the trigger's end event
      else if (sessionEnd && !beginTrigger_q)
      begin
        armed_d = 1'b0;
        breakRequest_d = breakEnable_q;
      end
    end
  end

  // Fill counter and full flag
  always @*
  begin
    validWordCount_d = validWordCount_q;
    bufferFull_d = bufferFull_q;
    if (armSet)
    begin
      validWordCount_d = `TBRPC_CNT_ZERO;
      bufferFull_d = 1'b0;
    end
    else if (storeNow)
    begin
      if (wrapNow)
      begin
        bufferFull_d = 1'b1;
      end
      // Begin mode stops at the first wrap; end mode keeps overwriting
      if (!(bufferFull_q && beginTrigger_q))
      begin
        validWordCount_d = validWordCount_q + `TBRPC_CNT_ONE;
      end
    end
  end

  // Read pointer: loaded with the oldest entry when storage stops
  always @*
  begin
    readPtr_d = readPtr_q;
    if (armed_q && !armed_d)
    begin
      if (bufferFull_d)
      begin
        readPtr_d = validWordCount_d;
      end
      else
      begin
        readPtr_d = `TBRPC_CNT_ZERO;
      end
    end
    else if (rdTraceWord)
    begin
      readPtr_d = readPtr_q + `TBRPC_CNT_ONE;
    end
  end

  // Page extension register
  always @*
  begin
    pageExt_d = pageExt_q;
    if (wrPageExt)
    begin
      pageExt_d = regWrData[7:0];
    end
  end

  // Read data, one cycle after the strobe
  always @*
  begin
    regRdData_d = 16'h0000;
    if (regRd)
    begin
      case (regAddr)
        `TBRPC_OFS_TRACE_WORD:
        begin
          if (rdTraceWord)
          begin
            regRdData_d = ramWord;
          end
        end
        `TBRPC_OFS_FILL_COUNT:
        begin
          regRdData_d = {8'h00, fillCountReg};
        end
        `TBRPC_OFS_PAGE_EXT:
        begin
          regRdData_d = {8'h00, pageExt_q};
        end
        `TBRPC_OFS_CONTROL_ONE:
        begin
          regRdData_d = {8'h00, controlReg};
        end
        default:
        begin
          regRdData_d = 16'h0000;
        end
      endcase
    end
  end

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      armed_q <= 1'b0;
      beginTrigger_q <= 1'b0;
      captureMode_q <= 2'h0;
      breakEnable_q <= 1'b0;
      breakRequest_q <= 1'b0;
      bufferFull_q <= 1'b0;
      validWordCount_q <= `TBRPC_CNT_ZERO;
      readPtr_q <= `TBRPC_CNT_ZERO;
      pageExt_q <= `TBRPC_CCX_RESET;
      regRdData_q <= 16'h0000;
    end
    else
    begin
      armed_q <= armed_d;
      beginTrigger_q <= beginTrigger_d;
      captureMode_q <= captureMode_d;
      breakEnable_q <= breakEnable_d;
      breakRequest_q <= breakRequest_d;
      bufferFull_q <= bufferFull_d;
      validWordCount_q <= validWordCount_d;
      readPtr_q <= readPtr_d;
      pageExt_q <= pageExt_d;
      regRdData_q <= regRdData_d;
    end
  end

  // Memory prefetches the next read address so back-to-back reads stay exact
  tbrpc_trace_ram uRam
  (
    .clk      (clk),
    .wrEn     (storeNow),
    .wrAddr   (validWordCount_q),
    .wrData   (storeWord),
    .rdAddr   (readPtr_d),
    .rdData_q (ramWord)
  );

  tbrpc_page_cmp uPageCmp
  (
    .clk                   (clk),
    .nrst                  (nrst),
    .pagingTypeSelect      (pageExt_q[7:`TBRPC_CCX_SEL_LO]),
    .extendedPageMatchBits (pageExt_q[`TBRPC_CCX_EXT_MSB:0]),
    .programPageIndex      (programPageIndex),
    .lowAddrMatch          (lowAddrMatch),
    .compCMatch_q          (compCMatch_q)
  );

endmodule

// *** tbrpc_defines.vh ***
// Register offsets, field positions and reset values of the trace readout block
`ifndef TBRPC_DEFINES_VH
`define TBRPC_DEFINES_VH

// Byte offsets on the register port
`define TBRPC_OFS_TRACE_WORD   8'h00
`define TBRPC_OFS_FILL_COUNT   8'h02
`define TBRPC_OFS_PAGE_EXT     8'h03
`define TBRPC_OFS_CONTROL_ONE  8'h04

// Control register fields
`define TBRPC_CTL_ARM          6
`define TBRPC_CTL_BEGIN        4
`define TBRPC_CTL_BRK          3
`define TBRPC_CTL_CAP_HI       1
`define TBRPC_CTL_CAP_LO       0
`define TBRPC_CTL_RESET        8'h00
`define TBRPC_CTL_WR_MASK      8'h5b

// Fill count register fields
`define TBRPC_CNT_FULL         7
`define TBRPC_CNT_MSB          5
`define TBRPC_CNT_ZERO         6'h00
`define TBRPC_CNT_ONE          6'h01
`define TBRPC_CNT_LAST         6'h3f

// Page extension register fields
`define TBRPC_CCX_SEL_LO       6
`define TBRPC_CCX_EXT_MSB      5
`define TBRPC_CCX_RESET        8'h00

// Page selector value that enables program page comparison
`define TBRPC_PAGING_TYPE_SELECT_PROGRAM   1'b1

// Widths
`define TBRPC_ADDR_W           6
`define TBRPC_DATA_W           16
`define TBRPC_DEPTH            64

`endif

// *** tbrpc_trace_ram.v ***
// Trace storage memory, 64 words, registered read port with write bypass
`include "tbrpc_defines.vh"

module tbrpc_trace_ram
(
  // Clock
  input wire         clk,
  // Write port
  input wire         wrEn,
  input wire [5:0]   wrAddr,
  input wire [15:0]  wrData,
  // Read port, data registered
  input wire [5:0]   rdAddr,
  output reg [15:0]  rdData_q
);

  reg [15:0] mem [0:`TBRPC_DEPTH-1];

  // No reset: contents stay undefined after reset
  always @(posedge clk)
  begin
    if (wrEn)
    begin
      mem[wrAddr] <= wrData;
    end
  end

  // Bypass keeps the prefetched word current when the same entry is written
  always @(posedge clk)
  begin
    if (wrEn && (wrAddr == rdAddr))
    begin
      rdData_q <= wrData;
    end
    else
    begin
      rdData_q <= mem[rdAddr];
    end
  end

endmodule

// *** tbrpc_page_cmp.v ***
// Comparator C extended page comparison, registered match result
`include "tbrpc_defines.vh"

module tbrpc_page_cmp
(
  // Clock and reset
  input wire        clk,
  input wire        nrst,
  // Configuration
  input wire [1:0]  pagingTypeSelect,
  input wire [5:0]  extendedPageMatchBits,
  // Core side
  input wire [5:0]  programPageIndex,
  input wire        lowAddrMatch,
  // Result
  output reg        compCMatch_q
);

  wire pageEn;
  wire pageHit;
  wire compCMatch_d;

  // Only the low selector bit counts; the upper one selects unbuilt pagers
  assign pageEn = (pagingTypeSelect[0] == `TBRPC_PAGING_TYPE_SELECT_PROGRAM);
  assign pageHit = (extendedPageMatchBits == programPageIndex);
  assign compCMatch_d = lowAddrMatch & (~pageEn | pageHit);

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      compCMatch_q <= 1'b0;
    end
    else
    begin
      compCMatch_q <= compCMatch_d;
    end
  end

endmodule

// *** tbrpc_assertions.sv ***
// Checker on the ports of the trace readout block
module tbrpc_assertions
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        nrst,
  // Register port
  input wire logic [7:0]  regAddr,
  input wire logic [15:0] regWrData,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic        regByte,
  input wire logic [15:0] regRdData_q,
  // Capture and core side
  input wire logic        storeValid,
  input wire logic        sessionEnd,
  input wire logic [5:0]  programPageIndex,
  input wire logic        lowAddrMatch,
  // Control and results
  input wire logic        armed_q,
  input wire logic        beginTrigger_q,
  input wire logic        breakRequest_q,
  input wire logic        bufferFull_q,
  input wire logic        compCMatch_q
);
  logic       brkEn_q;
  logic [7:0] pageExt_q;
  logic [6:0] nStored_q;
  wire        ctlWr = regWr && regAddr == 8'h04;

  // Saturates at 64 so the full flag can be tied to it for good
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      brkEn_q   <= 1'b0;
      pageExt_q <= 8'h00;
      nStored_q <= 7'h00;
    end
    else
    begin
      if (ctlWr)
        brkEn_q <= regWrData[3];
      if (regWr && regAddr == 8'h03)
        pageExt_q <= regWrData[7:0];
      if (ctlWr && regWrData[6])
        nStored_q <= 7'h00;
      else if (storeValid && armed_q && nStored_q != 7'h40)
        nStored_q <= nStored_q + 7'h01;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  property p_idle;
    !regRd |=> regRdData_q == 16'h0000;
  endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  property p_byte;
    regRd && (regAddr == 8'h01 || regAddr == 8'h00 && regByte)
      |=> regRdData_q == 16'h0000;
  endproperty
  a_byte: assert property (p_byte) else $error("bad read not zero");
  property p_armrd;
    regRd && armed_q && regAddr == 8'h00 |=> regRdData_q == 16'h0000;
  endproperty
  a_armrd: assert property (p_armrd) else $error("armed read data");
  property p_full;
    bufferFull_q == (nStored_q == 7'h40);
  endproperty
  a_full: assert property (p_full) else $error("full flag wrong");
  property p_armclr;
    ctlWr && regWrData[6] |=> !bufferFull_q;
  endproperty
  a_armclr: assert property (p_armclr) else $error("arm kept full");
  property p_disarm;
    $rose(bufferFull_q) && beginTrigger_q |-> !armed_q;
  endproperty
  a_disarm: assert property (p_disarm) else $error("still armed");
  property p_brk;
    $rose(bufferFull_q) && beginTrigger_q && brkEn_q |-> ##[0:1] breakRequest_q;
  endproperty
  a_brk: assert property (p_brk) else $error("no break request");
  property p_pulse;
    breakRequest_q |=> !breakRequest_q;
  endproperty
  a_pulse: assert property (p_pulse) else $error("break too long");
  property p_endtrg;
    sessionEnd && armed_q && !beginTrigger_q && !ctlWr |=> !armed_q;
  endproperty
  a_endtrg: assert property (p_endtrg) else $error("end kept arm");
  property p_page;
    1 |=> compCMatch_q == $past(lowAddrMatch &&
      (!pageExt_q[6] || pageExt_q[5:0] == programPageIndex));
  endproperty
  a_page: assert property (p_page) else $error("page match wrong");

  c_full: cover property ($rose(bufferFull_q));
  c_brk: cover property (breakRequest_q);
  c_match: cover property (compCMatch_q);
endmodule

// *** tbrpc_capture_src.sv ***
// Trigger logic stand-in that feeds words into the trace store
module tbrpc_capture_src
(
  // Clock
  input wire logic    clk,
  // Store stream
  output logic        storeValid,
  output logic [15:0] storeWord
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    storeValid = 1'b0;
    storeWord  = 16'h0000;
  end
  // Idle word is inverted so a stale value never passes for a new one
  task automatic emit(input logic [15:0] base, input int n, input logic slow);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      storeValid <= 1'b1;
      storeWord  <= base + 16'(i);
      if (slow)
      begin
        @(posedge clk);
        storeValid <= 1'b0;
      end
    end
    @(posedge clk);
    storeValid <= 1'b0;
    storeWord  <= ~storeWord;
  endtask
endmodule

// *** test_trace_buffer_readout_and_page_compare.sv ***
// Self-checking bench for the trace readout block
module test_trace_buffer_readout_and_page_compare;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk;
  logic        nrst;
  logic [7:0]  regAddr;
  logic [15:0] regWrData;
  logic        regWr;
  logic        regRd;
  logic        regByte;
  logic        sessionEnd;
  logic [5:0]  programPageIndex;
  logic        lowAddrMatch;
  logic        storeValid;
  logic [15:0] storeWord;
  logic [15:0] regRdData_q;
  logic        armed_q;
  logic        breakRequest_q;
  logic        bufferFull_q;
  logic        compCMatch_q;
  int          n_errors = 0;
  int          tests_run = 0;

  tbrpc_capture_src i_src (.clk(clk), .storeValid(storeValid),
    .storeWord(storeWord));
  tbrpc_trace_readout i_dut (.clk(clk), .nrst(nrst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regByte(regByte),
    .regRdData_q(regRdData_q), .storeValid(storeValid),
    .storeWord(storeWord), .sessionEnd(sessionEnd),
    .programPageIndex(programPageIndex), .lowAddrMatch(lowAddrMatch),
    .armed_q(armed_q), .beginTrigger_q(), .captureMode_q(),
    .breakRequest_q(breakRequest_q), .bufferFull_q(bufferFull_q),
    .compCMatch_q(compCMatch_q));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] s, e);
    tests_run++;
    if (s !== e)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    regWr     <= 1'b1;
    regAddr   <= a;
    regWrData <= {8'h00, d};
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic b, input logic [15:0] e);
    @(posedge clk);
    regRd   <= 1'b1;
    regAddr <= a;
    regByte <= b;
    @(posedge clk);
    regRd   <= 1'b0;
    regByte <= 1'b0;
    #1 chk("read data", regRdData_q, e);
  endtask
  task automatic rdAll(input logic [15:0] base);
    for (int k = 0; k < 64; k++)
      rd(8'h00, 1'b0, base + 16'(k));
  endtask
  // Window of three cycles allows the pulse to trail the store
  task automatic brkSeen(input logic [15:0] e);
    logic [15:0] hits;
    hits = 16'h0000;
    repeat (3)
    begin
      #1;
      if (breakRequest_q === 1'b1)
        hits++;
      @(posedge clk);
    end
    chk("break pulses", hits, e);
    chk("armed", 16'(armed_q), 16'h0000);
  endtask

  task automatic pageScen;
    logic [2:0] j;
    logic       e;
    rd(8'h03, 1'b0, 16'h0000);
    wr(8'h07, 8'hff);
    rd(8'h07, 1'b0, 16'h0000);
    for (int i = 0; i < 8; i++)
    begin
      j = 3'(i);
      wr(8'h03, {j[2:1], 6'h05});
      programPageIndex <= j[0] ? 6'h06 : 6'h05;
      lowAddrMatch     <= j != 3'h4;
      e = j != 3'h4 && (!j[1] || !j[0]);
      repeat (2) @(posedge clk);
      #1 chk("page match", 16'(compCMatch_q), 16'(e));
      rd(8'h03, 1'b0, {8'h00, j[2:1], 6'h05});
    end
  endtask
  task automatic beginScen;
    wr(8'h04, 8'h58);
    i_src.emit(16'ha000, 63, 1'b0);
    rd(8'h02, 1'b0, 16'h003f);
    i_src.emit(16'ha03f, 1, 1'b0);
    brkSeen(16'h0001);
    rd(8'h04, 1'b0, 16'h0018);
    i_src.emit(16'hbeef, 1, 1'b0);
    rd(8'h02, 1'b0, 16'h0080);
    rd(8'h00, 1'b1, 16'h0000);
    rd(8'h01, 1'b0, 16'h0000);
    rdAll(16'ha000);
  endtask
  task automatic endScen;
    wr(8'h04, 8'h4a);
    rd(8'h02, 1'b0, 16'h0000);
    i_src.emit(16'hb000, 66, 1'b1);
    rd(8'h02, 1'b0, 16'h0082);
    rd(8'h00, 1'b0, 16'h0000);
    @(posedge clk);
    sessionEnd <= 1'b1;
    @(posedge clk);
    sessionEnd <= 1'b0;
    brkSeen(16'h0001);
    rd(8'h04, 1'b0, 16'h000a);
    rdAll(16'hb002);
    wr(8'h04, 8'h50);
    rd(8'h02, 1'b0, 16'h0000);
    i_src.emit(16'hc000, 64, 1'b0);
    brkSeen(16'h0000);
  endtask

  initial
  begin
    nrst = 1'b0;
    regAddr = 8'h00;
    regWrData = 16'h0000;
    regWr = 1'b0;
    regRd = 1'b0;
    regByte = 1'b0;
    sessionEnd = 1'b0;
    programPageIndex = 6'h00;
    lowAddrMatch = 1'b0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    pageScen;
    beginScen;
    endScen;
    print_verdict;
  end
  // The run needs under 2000 cycles
  initial
  begin
    #500us;
    n_errors++;
    print_verdict;
  end
endmodule

bind tbrpc_trace_readout tbrpc_assertions i_chk (.*);
